//--- rtl/dcp_regs.sv
`timescale 1ns/1ps
module dcp_regs
  import dcp_pkg::*;
#(
  // value is arbitrary
  parameter logic [15:0] MODEL_CODE = 16'h00A5,
  parameter logic [15:0] POWER_CODE = 16'h0006,
  parameter logic        VOLT_CLASS = 1'b0,
  // version values are arbitrary
  parameter logic [7:0]  FW_MAJOR   = 8'h02,
  parameter logic [7:0]  FW_MINOR   = 8'h03,
  parameter logic [15:0] RUN_BLOCK  = 16'h0000
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        req_valid,
  input  wire dcp_req_t    req,
  output logic             req_ready,
  output logic             rsp_valid,
  output dcp_rsp_t         rsp,
  input  wire dcp_mon_t    mon,
  input  wire logic        running,
  input  wire logic [1:0]  cmd_src,
  input  wire logic [4:0]  freq_src,
  output dcp_ctl_t         ctl,
  output logic             fault_reset,
  output logic             estop,
  output logic             unlocked
);

  // ==========================================================
  // request sequencer
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,
    ST_ANSWER = 2'b10
  } dcp_state_t;

  dcp_state_t state_q, state_d;
  logic       accept;
  logic [7:0] exc;
  logic       wr_ok;

  assign req_ready = (state_q == ST_IDLE);
  assign accept = req_valid && req_ready;
  assign rsp_valid = (state_q == ST_ANSWER);

  always_comb begin
    case (state_q)
      ST_IDLE: begin
        state_d = accept ? ST_ANSWER : ST_IDLE;
      end
      ST_ANSWER: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // access permission
  logic lock_q, lock_d;

  dcp_access_check #(
    .RUN_BLOCK (RUN_BLOCK)
  ) u_check (
    .addr    (req.addr),
    .write   (req.write),
    .lock    (lock_q),
    .running (running),
    .exc     (exc)
  );

  // a refused write leaves every writable word untouched; only the answer register takes its exception code
  assign wr_ok = accept && req.write && (exc == EXC_NONE);

  // ==========================================================
  // writable words
  logic [15:0] freq_q, freq_d;
  logic [15:0] up_q, up_d;
  logic [15:0] down_q, down_d;
  logic        cmd_wr;
  logic [2:0]  run_bits;
  logic [15:0] cmd_word;

  always_comb begin
    lock_d = lock_q;
    freq_d = freq_q;
    up_d = up_q;
    down_d = down_q;
    if (wr_ok) begin
      case (req.addr)
        ADDR_LOCK: lock_d = req.wdata[0];
        ADDR_FREQ: freq_d = req.wdata;
        ADDR_ACCEL: up_d = req.wdata;
        ADDR_DECEL: down_d = req.wdata;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_q <= LOCK_RST;
      freq_q <= FREQ_RST;
      up_q <= ACCEL_RST;
      down_q <= DECEL_RST;
    end else begin
      lock_q <= lock_d;
      freq_q <= freq_d;
      up_q <= up_d;
      down_q <= down_d;
    end
  end

  assign cmd_wr = wr_ok && (req.addr == ADDR_CMD);

  dcp_cmd_word u_cmd (
    .clk         (clk),
    .arst_n      (arst_n),
    .wr_en       (cmd_wr),
    .wdata       (req.wdata),
    .cmd_src     (cmd_src),
    .freq_src    (freq_src),
    .run_bits    (run_bits),
    .fault_reset (fault_reset),
    .estop       (estop),
    .rd_word     (cmd_word)
  );

  assign ctl.freq_ref = freq_q;
  assign ctl.ramp_up = up_q;
  assign ctl.ramp_down = down_q;
  assign ctl.stop = run_bits[CMD_STOP];
  assign ctl.fwd = run_bits[CMD_FWD];
  assign ctl.rev = run_bits[CMD_REV];
  assign unlocked = lock_q;

  // ==========================================================
  // read mux and answer register
  logic [15:0] rd_val;
  dcp_rsp_t    rsp_q, rsp_d;

  always_comb begin
    case (req.addr)
      ADDR_MODEL:  rd_val = MODEL_CODE;
      ADDR_POWER:  rd_val = POWER_CODE;
      ADDR_VCLASS: rd_val = {15'h0000, VOLT_CLASS};
      ADDR_FWREV:  rd_val = {FW_MAJOR, FW_MINOR};
      // lock reads as 0 or 1
      ADDR_LOCK:   rd_val = {15'h0000, lock_q};
      ADDR_FREQ:   rd_val = freq_q;
      ADDR_CMD:    rd_val = cmd_word;
      ADDR_ACCEL:  rd_val = up_q;
      ADDR_DECEL:  rd_val = down_q;
      ADDR_CURR:   rd_val = mon.current;
      ADDR_OFREQ:  rd_val = mon.freq;
      ADDR_OVOLT:  rd_val = mon.volt;
      ADDR_DCBUS:  rd_val = mon.dcbus;
      ADDR_OPOW:   rd_val = mon.power;
      default:     rd_val = 16'h0000;
    endcase
  end

  always_comb begin
    rsp_d = rsp_q;
    if (accept) begin
      rsp_d.exc = exc;
      // writes and refusals answer with zero data
      rsp_d.rdata = (req.write || exc != EXC_NONE) ? 16'h0000 : rd_val;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  assign rsp = rsp_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_answer_timing: assert property (
    accept |=> rsp_valid ##1 !rsp_valid)
    else $error("answer not exactly one cycle after request");

  a_no_overlap: assert property (
    rsp_valid |-> !req_ready)
    else $error("request taken while answering");

  a_lock_update: assert property (
    wr_ok && req.addr == ADDR_LOCK |=> lock_q == $past(req.wdata[0]))
    else $error("lock word did not take written value");

  a_lock_kept: assert property (
    !(wr_ok && req.addr == ADDR_LOCK) |=> $stable(lock_q))
    else $error("lock word changed without a write");

  a_denied_locked: assert property (
    accept && req.write && !lock_q && req.addr != ADDR_LOCK
      && req.addr <= ADDR_LAST
    |=> rsp_valid && rsp.exc == EXC_DENIED)
    else $error("locked write not refused");

  a_denied_ro: assert property (
    accept && req.write && req.addr == ADDR_CURR
    |=> rsp.exc == EXC_DENIED ##0 $stable(ctl))
    else $error("read-only write not refused");

  a_bad_addr: assert property (
    accept && req.addr > ADDR_LAST |=> rsp.exc == EXC_BAD_ADDR)
    else $error("unmapped address not refused");

  a_freq_store: assert property (
    wr_ok && req.addr == ADDR_FREQ
    |=> ctl.freq_ref == $past(req.wdata))
    else $error("frequency reference not stored");

  a_ramp_store: assert property (
    wr_ok && req.addr == ADDR_DECEL
    |=> ctl.ramp_down == $past(req.wdata) && $stable(ctl.ramp_up))
    else $error("ramp time not stored");

  a_run_bits: assert property (
    cmd_wr |=> {ctl.rev, ctl.fwd, ctl.stop}
      == $past(req.wdata[CMD_REV:CMD_STOP]))
    else $error("run bits not stored");

  a_monitor_read: assert property (
    accept && !req.write && req.addr == ADDR_CURR
    |=> rsp.rdata == $past(mon.current) && rsp.exc == EXC_NONE)
    else $error("current monitor read wrong");

  a_version_read: assert property (
    accept && !req.write && req.addr == ADDR_FWREV
    |=> rsp.rdata == {FW_MAJOR, FW_MINOR})
    else $error("version word read wrong");

  a_cmd_read: assert property (
    accept && !req.write && req.addr == ADDR_CMD
    |=> rsp.rdata[15:13] == 3'h0 && rsp.rdata[5:3] == 3'h0
      && rsp.rdata[12:8] == $past(freq_src)
      && rsp.rdata[7:6] == $past(cmd_src))
    else $error("command word readback wrong");

  a_ramp_up_store: assert property (
    wr_ok && req.addr == ADDR_ACCEL
    |=> ctl.ramp_up == $past(req.wdata) && $stable(ctl.ramp_down))
    else $error("ramp up time not stored");

  a_denied_running: assert property (
    accept && req.write && running && RUN_BLOCK[req.addr[3:0]]
      && req.addr <= ADDR_LAST
    |=> rsp.exc == EXC_DENIED)
    else $error("write while running not refused");

  a_denied_keeps: assert property (
    accept && req.write && exc != EXC_NONE
    |=> $stable(ctl) && $stable(unlocked) && !fault_reset && !estop)
    else $error("refused write changed state");

  a_write_zero: assert property (
    accept && req.write |=> rsp.rdata == 16'h0000)
    else $error("write answered with data");

  a_read_still: assert property (
    accept && !req.write |=> $stable(ctl) && $stable(unlocked))
    else $error("read changed a register");

  a_lock_read: assert property (
    accept && !req.write && req.addr == ADDR_LOCK
    |=> rsp.rdata == {15'h0000, $past(lock_q)})
    else $error("lock word read wrong");

  a_model_read: assert property (
    accept && !req.write && req.addr == ADDR_MODEL
    |=> rsp.rdata == MODEL_CODE)
    else $error("model word read wrong");

  a_power_read: assert property (
    accept && !req.write && req.addr == ADDR_POWER
    |=> rsp.rdata == POWER_CODE)
    else $error("capacity word read wrong");

  a_vclass_read: assert property (
    accept && !req.write && req.addr == ADDR_VCLASS
    |=> rsp.rdata[15:1] == 15'h0000 && rsp.rdata[0] == VOLT_CLASS)
    else $error("voltage class word read wrong");

  c_unlock: cover property (
    wr_ok && req.addr == ADDR_LOCK && req.wdata[0]);
  c_denied: cover property (rsp_valid && rsp.exc == EXC_DENIED);
  c_bad_addr: cover property (rsp_valid && rsp.exc == EXC_BAD_ADDR);
  c_cmd_write: cover property (cmd_wr ##2 accept && req.addr == ADDR_CMD);

endmodule

//--- rtl/dcp_pkg.sv
package dcp_pkg;

  // ==========================================================
  // register map
  localparam int unsigned DCP_W = 16;
  localparam logic [15:0] ADDR_MODEL = 16'h0000;
  localparam logic [15:0] ADDR_POWER = 16'h0001;
  localparam logic [15:0] ADDR_VCLASS = 16'h0002;
  localparam logic [15:0] ADDR_FWREV = 16'h0003;
  localparam logic [15:0] ADDR_LOCK = 16'h0004;
  localparam logic [15:0] ADDR_FREQ = 16'h0005;
  localparam logic [15:0] ADDR_CMD = 16'h0006;
  localparam logic [15:0] ADDR_ACCEL = 16'h0007;
  localparam logic [15:0] ADDR_DECEL = 16'h0008;
  localparam logic [15:0] ADDR_CURR = 16'h0009;
  localparam logic [15:0] ADDR_OFREQ = 16'h000A;
  localparam logic [15:0] ADDR_OVOLT = 16'h000B;
  localparam logic [15:0] ADDR_DCBUS = 16'h000C;
  localparam logic [15:0] ADDR_OPOW = 16'h000D;
  localparam logic [15:0] ADDR_LAST = 16'h000D;

  // ==========================================================
  // exception codes, 00 means a normal answer
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_BAD_ADDR = 8'h02;
  localparam logic [7:0] EXC_DENIED = 8'h14;

  // ==========================================================
  // reset values
  localparam logic LOCK_RST = 1'b0;
  localparam logic [15:0] FREQ_RST = 16'h0000;
  localparam logic [15:0] ACCEL_RST = 16'h0032;
  localparam logic [15:0] DECEL_RST = 16'h0032;

  // ==========================================================
  // run command word fields
  localparam int unsigned CMD_STOP = 0;
  localparam int unsigned CMD_FWD = 1;
  localparam int unsigned CMD_REV = 2;
  localparam int unsigned CMD_FRST = 3;
  localparam int unsigned CMD_ESTOP = 4;
  localparam int unsigned CMD_SRC_LSB = 6;
  localparam int unsigned FSRC_LSB = 8;

  typedef struct packed {
    logic        write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } dcp_req_t;

  typedef struct packed {
    logic [7:0]  exc;
    logic [15:0] rdata;
  } dcp_rsp_t;

  typedef struct packed {
    logic [15:0] current;
    logic [15:0] freq;
    logic [15:0] volt;
    logic [15:0] dcbus;
    logic [15:0] power;
  } dcp_mon_t;

  typedef struct packed {
    logic [15:0] freq_ref;
    logic [15:0] ramp_up;
    logic [15:0] ramp_down;
    logic        stop;
    logic        fwd;
    logic        rev;
  } dcp_ctl_t;

endpackage

//--- rtl/dcp_access_check.sv
`timescale 1ns/1ps
module dcp_access_check
  import dcp_pkg::*;
#(
  parameter logic [15:0] RUN_BLOCK = 16'h0000
) (
  input  wire logic [15:0] addr,
  input  wire logic        write,
  input  wire logic        lock,
  input  wire logic        running,
  output logic [7:0]       exc
);

  logic ro;

  always_comb begin
    case (addr)
      ADDR_LOCK, ADDR_FREQ, ADDR_CMD,
      ADDR_ACCEL, ADDR_DECEL: ro = 1'b0;
      default: ro = 1'b1;
    endcase
  end

  // the lock word itself stays writable, else it could never unlock
  always_comb begin
    exc = EXC_NONE;
    if (addr > ADDR_LAST) begin
      exc = EXC_BAD_ADDR;
    end else if (write) begin
      if (ro) begin
        exc = EXC_DENIED;
      end else if (addr != ADDR_LOCK && !lock) begin
        exc = EXC_DENIED;
      end else if (running && RUN_BLOCK[addr[3:0]]) begin
        exc = EXC_DENIED;
      end
    end
  end

endmodule

//--- rtl/dcp_cmd_word.sv
`timescale 1ns/1ps
module dcp_cmd_word
  import dcp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        wr_en,
  input  wire logic [15:0] wdata,
  input  wire logic [1:0]  cmd_src,
  input  wire logic [4:0]  freq_src,
  output logic [2:0]       run_bits,
  output logic             fault_reset,
  output logic             estop,
  output logic [15:0]      rd_word
);

  logic [2:0] run_q, run_d;
  logic       frst_q, frst_d;
  logic       frp_q, frp_d;
  logic       esp_q, esp_d;

  always_comb begin
    run_d = run_q;
    frst_d = frst_q;
    frp_d = 1'b0;
    esp_d = 1'b0;
    if (wr_en) begin
      run_d = wdata[CMD_REV:CMD_STOP];
      frst_d = wdata[CMD_FRST];
      frp_d = wdata[CMD_FRST] && !frst_q;
      esp_d = wdata[CMD_ESTOP];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run_q <= 3'h0;
      frst_q <= 1'b0;
      frp_q <= 1'b0;
      esp_q <= 1'b0;
    end else begin
      run_q <= run_d;
      frst_q <= frst_d;
      frp_q <= frp_d;
      esp_q <= esp_d;
    end
  end

  assign run_bits = run_q;
  assign fault_reset = frp_q;
  assign estop = esp_q;
  assign rd_word = {3'h0, freq_src, cmd_src, 3'h0, run_q};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_frst_edge: assert property (
    fault_reset |-> $past(wr_en && wdata[CMD_FRST] && !frst_q))
    else $error("fault reset without a 0 to 1 write");
  a_estop_pulse: assert property (
    wr_en && wdata[CMD_ESTOP] |=> estop ##1 (!estop || wr_en))
    else $error("emergency stop pulse missing");
  c_fault_reset: cover property (fault_reset);

endmodule

//--- bench/dcp_master.sv
`timescale 1ns/1ps
module dcp_master
  import dcp_pkg::*;
(
  input  wire logic     clk,
  output logic          req_valid,
  output dcp_req_t      req,
  input  wire logic     req_ready,
  input  wire logic     rsp_valid,
  input  wire dcp_rsp_t rsp
);
  // ==========================================================
  // request driver
  initial begin
    req_valid = 1'b0;
    req = '0;
  end

  // one word per request; released lines carry the inverse so stale
  // values never pass for a fresh request
  task automatic xfer(input logic w, input logic [15:0] a,
                      input logic [15:0] d, output dcp_rsp_t r,
                      output bit ok);
    int n;
    n = 0;
    @(negedge clk);
    while (req_ready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    req_valid = 1'b1;
    req = '{write: w, addr: a, wdata: d};
    @(negedge clk);
    req_valid = 1'b0;
    req = '{write: ~w, addr: ~a, wdata: ~d};
    ok = (n < 20) && (rsp_valid === 1'b1);
    r = rsp;
  endtask
endmodule

//--- bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import dcp_pkg::*;
  logic       clk, arst_n, req_valid, req_ready, rsp_valid, running;
  logic       fault_reset, estop, unlocked;
  logic [1:0] cmd_src;
  logic [4:0] freq_src;
  dcp_req_t   req;
  dcp_rsp_t   rsp;
  dcp_mon_t   mon;
  dcp_ctl_t   ctl;
  int         bad_count, compares;

  // ==========================================================
  // design and master
  // model code and version values are arbitrary
  dcp_regs #(.MODEL_CODE(16'h005A), .POWER_CODE(16'hFFFF),
    .VOLT_CLASS(1'b1), .FW_MAJOR(8'h07),
    .RUN_BLOCK(16'h0020)) u_dcp_regs (.clk(clk), .arst_n(arst_n),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp(rsp), .mon(mon), .running(running),
    .cmd_src(cmd_src), .freq_src(freq_src), .ctl(ctl),
    .fault_reset(fault_reset), .estop(estop), .unlocked(unlocked));

  dcp_master u_dcp_master (.clk(clk), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // helpers
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic acc(input logic w, input logic [15:0] a,
                     input logic [15:0] d, input logic [7:0] ex,
                     input logic [15:0] rd);
    dcp_rsp_t r;
    bit       ok;
    u_dcp_master.xfer(w, a, d, r, ok);
    if (!ok) begin
      bad_count++;
      $display("ERROR %0t no answer at %h", $time, a);
      stop_test();
    end
    check({8'h00, r.exc}, {8'h00, ex}, "exception");
    check(r.rdata, rd, "read data");
  endtask

  // ==========================================================
  // scenarios
  task automatic t_ident();
    logic [15:0] exp [4];
    exp = '{16'h005A, 16'hFFFF, 16'h0001, 16'h0703};
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, 16'(i), 16'h0000, EXC_NONE, exp[i]);
    end
    acc(1'b1, ADDR_FWREV, 16'h1234, EXC_DENIED, 16'h0000);
    acc(1'b0, ADDR_FWREV, 16'h0000, EXC_NONE, 16'h0703);
    $display("t_ident done");
  endtask

  task automatic t_lock();
    acc(1'b0, ADDR_LOCK, 16'h0000, EXC_NONE, 16'h0000);
    check({15'h0, unlocked}, 16'h0000, "unlocked at reset");
    acc(1'b1, ADDR_FREQ, 16'h1388, EXC_DENIED, 16'h0000);
    acc(1'b0, ADDR_FREQ, 16'h0000, EXC_NONE, 16'h0000);
    acc(1'b0, ADDR_ACCEL, 16'h0000, EXC_NONE, ACCEL_RST);
    acc(1'b1, ADDR_LOCK, 16'h0001, EXC_NONE, 16'h0000);
    check({15'h0, unlocked}, 16'h0001, "unlocked");
    // reference stays inside the start to maximum frequency span
    acc(1'b1, ADDR_FREQ, 16'h1388, EXC_NONE, 16'h0000);
    acc(1'b1, ADDR_ACCEL, 16'h0064, EXC_NONE, 16'h0000);
    acc(1'b1, ADDR_DECEL, 16'h00C8, EXC_NONE, 16'h0000);
    running = 1'b1;
    acc(1'b1, ADDR_FREQ, 16'h0BB8, EXC_DENIED, 16'h0000);
    running = 1'b0;
    acc(1'b0, ADDR_FREQ, 16'h0000, EXC_NONE, 16'h1388);
    acc(1'b0, ADDR_ACCEL, 16'h0000, EXC_NONE, 16'h0064);
    acc(1'b0, ADDR_DECEL, 16'h0000, EXC_NONE, 16'h00C8);
    check(ctl.freq_ref, 16'h1388, "ctl freq");
    check(ctl.ramp_down, 16'h00C8, "ctl decel");
    check(ctl.ramp_up, 16'h0064, "ctl accel");
    $display("t_lock done");
  endtask

  task automatic t_cmd();
    acc(1'b1, ADDR_CMD, 16'h0018, EXC_NONE, 16'h0000);
    check({14'h0, fault_reset, estop}, 16'h0003, "pulses 1");
    acc(1'b1, ADDR_CMD, 16'h0018, EXC_NONE, 16'h0000);
    check({14'h0, fault_reset, estop}, 16'h0001, "pulses 2");
    acc(1'b1, ADDR_CMD, 16'h0000, EXC_NONE, 16'h0000);
    check({14'h0, fault_reset, estop}, 16'h0000, "pulses 3");
    acc(1'b1, ADDR_CMD, 16'h0008, EXC_NONE, 16'h0000);
    check({14'h0, fault_reset, estop}, 16'h0002, "pulses 4");
    acc(1'b1, ADDR_CMD, 16'hFFE2, EXC_NONE, 16'h0000);
    acc(1'b0, ADDR_CMD, 16'h0000, EXC_NONE, 16'h13C2);
    check({13'h0, ctl.stop, ctl.fwd, ctl.rev}, 16'h0002, "run");
    acc(1'b1, ADDR_CMD, 16'h0005, EXC_NONE, 16'h0000);
    acc(1'b0, ADDR_CMD, 16'h0000, EXC_NONE, 16'h13C5);
    $display("t_cmd done");
  endtask

  // reset in mid-run must bring every word back to its reset value
  task automatic t_reset();
    arst_n = 1'b0;
    @(negedge clk);
    arst_n = 1'b1;
    check(ctl.freq_ref, FREQ_RST, "freq rst");
    check(ctl.ramp_up, ACCEL_RST, "accel rst");
    check(ctl.ramp_down, DECEL_RST, "decel rst");
    check({13'h0, ctl.stop, ctl.fwd, ctl.rev}, 16'h0000, "run rst");
    check({15'h0, unlocked}, {15'h0, LOCK_RST}, "lock rst");
    acc(1'b1, ADDR_FREQ, 16'h0100, EXC_DENIED, 16'h0000);
    acc(1'b0, ADDR_CMD, 16'h0000, EXC_NONE, 16'h13C0);
    $display("t_reset done");
  endtask

  task automatic t_mon();
    logic [15:0] exp [5];
    exp = '{16'h0123, 16'h1388, 16'h0DC0, 16'h0C80, 16'h0055};
    mon = '{exp[0], exp[1], exp[2], exp[3], exp[4]};
    for (int i = 0; i < 5; i++) begin
      acc(1'b0, 16'(9 + i), 16'h0000, EXC_NONE, exp[i]);
    end
    acc(1'b1, ADDR_CURR, 16'h0001, EXC_DENIED, 16'h0000);
    acc(1'b0, 16'h000E, 16'h0000, EXC_BAD_ADDR, 16'h0000);
    acc(1'b1, 16'h0020, 16'h0001, EXC_BAD_ADDR, 16'h0000);
    $display("t_mon done");
  endtask

  task automatic t_relock();
    acc(1'b1, ADDR_LOCK, 16'h0000, EXC_NONE, 16'h0000);
    check({15'h0, unlocked}, 16'h0000, "relocked");
    acc(1'b1, ADDR_CMD, 16'h0002, EXC_DENIED, 16'h0000);
    cmd_src = 2'h1;
    freq_src = 5'h11;
    acc(1'b0, ADDR_CMD, 16'h0000, EXC_NONE, 16'h1140);
    $display("t_relock done");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    arst_n = 1'b0;
    running = 1'b0;
    cmd_src = 2'h3;
    freq_src = 5'h13;
    mon = '0;
    bad_count = 0;
    compares = 0;
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    t_ident();
    t_lock();
    t_cmd();
    t_reset();
    t_mon();
    t_relock();
    stop_test();
  end
endmodule
